// file: core/hco_defines.svh
/*
 * Register offsets, field positions, reset values and widths of the
 * pointer overlay control block.
 * Assumes byte addresses on the register port, one 32-bit word per register.
 */
`ifndef HCO_DEFINES_SVH
`define HCO_DEFINES_SVH

`define HCO_ADDR_W          8
`define HCO_OFF_CONTROL     8'h80
`define HCO_OFF_STATE       8'h84
`define HCO_OFF_POSITION    8'h90

`define HCO_SHOW_BIT        0
`define HCO_DIM_LSB         1
`define HCO_DIM_MSB         3
`define HCO_FMT_LSB         4
`define HCO_FMT_MSB         6
`define HCO_PENDING_BIT     31

`define HCO_FMT_RESET       3'h0
`define HCO_DIM_RESET       3'h0
`define HCO_SHOW_RESET      1'h0

`define HCO_FETCH_ALIGN_W   7
`define HCO_DIM_32          7'h20
`define HCO_DIM_48          7'h30
`define HCO_DIM_64          7'h40

`endif

// file: core/hco_pkg.sv
/*
 * Types shared by the pointer overlay control block.
 * Assumes hco_defines.svh is compiled with it.
 */
package hco_pkg;

    typedef enum logic [2:0] {
        FMT_TWO_COLOUR   = 3'h0,
        FMT_THREE_COLOUR = 3'h1,
        FMT_FOUR_COLOUR  = 3'h2,
        FMT_ARGB         = 3'h3,
        FMT_MASKED_ARGB  = 3'h4
    } hco_fmt_t;

    typedef enum logic [2:0] {
        DIM_32 = 3'h0,
        DIM_48 = 3'h1,
        DIM_64 = 3'h2
    } hco_dim_t;

    typedef enum logic [1:0] {
        BPP_8  = 2'h0,
        BPP_16 = 2'h1,
        BPP_32 = 2'h2
    } hco_bpp_t;

    typedef enum logic [0:0] {
        UPD_IDLE  = 1'h0,
        UPD_ARMED = 1'h1
    } hco_upd_t;

endpackage

// file: core/hco_overlay.sv
/*
 * Pointer overlay control: double-buffered control register, pending-update
 * flag armed by a position write, live status, and the pixel merge stage.
 * Assumes a vertical blank pulse from the frame timing generator and that
 * the merged pixel feeds the colour lookup and gamma stage downstream.
 */
// Functional notes
// R1: Control writes go to a holding copy.
// R2: Held settings applied at armed vertical blank.
// R3: Stopped engine makes control writes immediate.
// R4: Format field 6:4, five codes, resets zero.
// R5: Dimension field 3:1: 32, 48, 64.
// R6: Show bit enables fetch and overlay.
// R7: Show change waits for frame end.
// R8: Status shows live format, dimension, show.
// R9: Status bit 31 reads pending flag.
// R10: Writing one to bit 31 cancels update.
// R11: Software avoids changes while pending.
// R12: Two-colour: colours, frame, inverted frame.
// R13: Three-colour: three colours, code 11 transparent.
// R14: Four-colour: four colours, none transparent.
// R15: ARGB blends by alpha and 255 minus alpha.
// R16: Masked ARGB: opaque, transparent, or XOR.
// R17: At 8 bpp use blue byte only.
// R18: At 16 bpp use low 5/6/5 bits; code takes the 6 bits from blue and the low 5 from green.
// R19: Merge happens ahead of colour lookup.
// R20: Fetch address aligned to 128 bytes.
// R21: Pending flag clears after applying settings.
// R22: Reserved live codes suppress the overlay.
`timescale 1ns/1ps
`include "hco_defines.svh"
`default_nettype none

module hco_overlay (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire logic [`HCO_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    input  wire logic                   display_engine_stopped_flag,
    input  wire logic                   vblank_pulse,
    input  wire hco_pkg::hco_bpp_t      display_bpp,
    input  wire logic [31:0]            fetch_base,
    output logic                        fetch_enable,
    output logic      [31:0]            fetch_addr,
    output logic      [6:0]             pointer_side_px,
    input  wire logic [23:0]            colour0,
    input  wire logic [23:0]            colour1,
    input  wire logic [23:0]            colour2,
    input  wire logic [23:0]            colour3,
    input  wire logic                   pix_valid,
    input  wire logic [23:0]            frame_pix,
    input  wire logic                   pointer_hit,
    input  wire logic [1:0]             pointer_code,
    input  wire logic [31:0]            pointer_argb,
    output logic                        mix_valid,
    output logic      [23:0]            mix_pix
);
    import hco_pkg::*;

    logic     rst_meta_n;
    logic     rst_n;
    logic [2:0] hold_fmt;
    logic [2:0] hold_dim;
    logic     hold_show;
    logic [2:0] pointer_live_format;
    logic [2:0] pointer_live_dimension;
    logic     live_show;
    hco_upd_t upd_state;
    hco_upd_t next_upd_state;
    logic     pointer_update_pending;
    logic     wr_control;
    logic     wr_state;
    logic     wr_position;
    logic     cancel;
    logic     apply;
    logic     fmt_ok;
    logic     dim_ok;
    logic     overlay_on;
    logic [23:0] width_mask;
    logic [23:0] next_mix;
    logic [31:0] next_rdata;
    logic [7:0]  argb_alpha;
    logic [23:0] cursor_view;
    logic [7:0]  chan_cur [3];
    logic [7:0]  chan_frm [3];
    logic [7:0]  chan_mix [3];
    logic [23:0] blend_pix;

    // Reset is released through two flops so removal is synchronous.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    assign wr_control  = reg_wr && (reg_addr == `HCO_OFF_CONTROL);
    assign wr_state    = reg_wr && (reg_addr == `HCO_OFF_STATE);
    assign wr_position = reg_wr && (reg_addr == `HCO_OFF_POSITION);
    // A cancel in the same cycle as a vertical blank wins, so nothing is applied.
    assign cancel      = wr_state && reg_wdata[`HCO_PENDING_BIT]; // R10
    assign apply       = vblank_pulse && (upd_state == UPD_ARMED) && !cancel; // R2

    // Holding copy always follows control writes.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_fmt  <= `HCO_FMT_RESET; // R4
            hold_dim  <= `HCO_DIM_RESET;
            hold_show <= `HCO_SHOW_RESET;
        end else if (wr_control) begin
            hold_fmt  <= reg_wdata[`HCO_FMT_MSB:`HCO_FMT_LSB]; // R1
            hold_dim  <= reg_wdata[`HCO_DIM_MSB:`HCO_DIM_LSB];
            hold_show <= reg_wdata[`HCO_SHOW_BIT];
        end
    end

    // Live settings change only at a frame boundary, so a show change
    // never cuts a frame in half; a stopped engine has no frame to protect.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pointer_live_format    <= `HCO_FMT_RESET;
            pointer_live_dimension <= `HCO_DIM_RESET;
            live_show              <= `HCO_SHOW_RESET;
        end else if (wr_control && display_engine_stopped_flag) begin
            pointer_live_format    <= reg_wdata[`HCO_FMT_MSB:`HCO_FMT_LSB]; // R3
            pointer_live_dimension <= reg_wdata[`HCO_DIM_MSB:`HCO_DIM_LSB];
            live_show              <= reg_wdata[`HCO_SHOW_BIT];
        end else if (apply) begin
            pointer_live_format    <= hold_fmt; // R2
            pointer_live_dimension <= hold_dim;
            live_show              <= hold_show; // R7
        end
    end

    // A new arm in the apply cycle keeps the flag set, so no arm is lost.
    always_comb begin
        next_upd_state = upd_state;
        case (upd_state)
            UPD_IDLE: begin
                if (wr_position && !display_engine_stopped_flag) begin
                    next_upd_state = UPD_ARMED;
                end
            end
            UPD_ARMED: begin
                if (wr_position) begin
                    next_upd_state = UPD_ARMED;
                end else if (cancel || apply) begin
                    next_upd_state = UPD_IDLE; // R10 R21
                end
            end
            default: begin
                next_upd_state = UPD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            upd_state <= UPD_IDLE; // R9
        end else begin
            upd_state <= next_upd_state;
        end
    end

    assign pointer_update_pending = (upd_state == UPD_ARMED);

    // Unmapped addresses and idle cycles read zero, so a stale answer never
    // lingers on the port after its one cycle.
    always_comb begin
        next_rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `HCO_OFF_CONTROL: next_rdata = {25'h0, hold_fmt, hold_dim, hold_show};
                `HCO_OFF_STATE:   next_rdata = {pointer_update_pending, 24'h0, pointer_live_format,
                                                pointer_live_dimension, live_show}; // R8 R9
                default:          next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    assign fmt_ok = (pointer_live_format <= FMT_MASKED_ARGB);
    assign dim_ok = (pointer_live_dimension <= DIM_64);
    assign overlay_on = live_show && fmt_ok && dim_ok; // R6 R22

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_enable <= 1'b0;
        end else begin
            fetch_enable <= overlay_on; // R6
        end
    end

    // The low address bits are forced to zero rather than trusted, so a
    // misaligned base can never start a fetch in the middle of a line.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr <= 32'h0;
        end else begin
            fetch_addr <= {fetch_base[31:`HCO_FETCH_ALIGN_W], {`HCO_FETCH_ALIGN_W{1'b0}}}; // R20
        end
    end

    // Reserved dimension codes fall back to the smallest side.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pointer_side_px <= `HCO_DIM_32;
        end else begin
            case (pointer_live_dimension)
                DIM_48:  pointer_side_px <= `HCO_DIM_48; // R5
                DIM_64:  pointer_side_px <= `HCO_DIM_64;
                default: pointer_side_px <= `HCO_DIM_32;
            endcase
        end
    end

    // Reduce a cursor pixel to the display depth.
    function automatic logic [23:0] depth_view(input logic [31:0] p, input hco_bpp_t b);
        case (b)
            BPP_8:   return {16'h0, p[7:0]}; // R17
            BPP_16:  return {8'h0, p[20:16], p[5:0], p[12:8]}; // R18
            default: return p[23:0];
        endcase
    endfunction

    assign argb_alpha  = pointer_argb[31:24];
    assign cursor_view = depth_view(pointer_argb, display_bpp);

    // Split cursor and frame into channels at the display depth; unused
    // channels stay zero so they blend to zero.
    always_comb begin
        chan_cur[0] = 8'h0;
        chan_cur[1] = 8'h0;
        chan_cur[2] = 8'h0;
        chan_frm[0] = 8'h0;
        chan_frm[1] = 8'h0;
        chan_frm[2] = 8'h0;
        case (display_bpp)
            BPP_8: begin
                chan_cur[0] = cursor_view[7:0]; // R17
                chan_frm[0] = frame_pix[7:0];
            end
            BPP_16: begin
                chan_cur[0] = {3'h0, cursor_view[4:0]}; // R18
                chan_cur[1] = {2'h0, cursor_view[10:5]};
                chan_cur[2] = {3'h0, cursor_view[15:11]};
                chan_frm[0] = {3'h0, frame_pix[4:0]};
                chan_frm[1] = {2'h0, frame_pix[10:5]};
                chan_frm[2] = {3'h0, frame_pix[15:11]};
            end
            default: begin
                chan_cur[0] = cursor_view[7:0];
                chan_cur[1] = cursor_view[15:8];
                chan_cur[2] = cursor_view[23:16];
                chan_frm[0] = frame_pix[7:0];
                chan_frm[1] = frame_pix[15:8];
                chan_frm[2] = frame_pix[23:16];
            end
        endcase
    end

    // Division by 255 is taken as a shift by 8; full alpha loses at most
    // one code step, which saves a divider per channel. The two weights
    // add up to 255, so the 16-bit sum cannot overflow.
    for (genvar i = 0; i < 3; i++) begin : g_blend
        logic [15:0] sum;
        assign sum         = 16'(argb_alpha) * 16'(chan_cur[i])
                           + 16'(8'hff - argb_alpha) * 16'(chan_frm[i]); // R15
        assign chan_mix[i] = sum[15:8];
    end

    // A 5- or 6-bit channel blends to no more than its inputs, so its
    // result fits its field without saturation.
    always_comb begin
        case (display_bpp)
            BPP_8:   blend_pix = {16'h0, chan_mix[0]};
            BPP_16:  blend_pix = {8'h0, chan_mix[2][4:0], chan_mix[1][5:0], chan_mix[0][4:0]};
            default: blend_pix = {chan_mix[2], chan_mix[1], chan_mix[0]};
        endcase
    end

    always_comb begin
        case (display_bpp)
            BPP_8:   width_mask = 24'h0000ff;
            BPP_16:  width_mask = 24'h00ffff;
            default: width_mask = 24'hffffff;
        endcase
    end

    always_comb begin
        next_mix = frame_pix;
        if (overlay_on && pointer_hit) begin
            case (pointer_live_format)
                FMT_TWO_COLOUR: begin
                    case (pointer_code)
                        2'h0:    next_mix = colour0; // R12
                        2'h1:    next_mix = colour1;
                        2'h2:    next_mix = frame_pix;
                        default: next_mix = ~frame_pix;
                    endcase
                end
                FMT_THREE_COLOUR: begin
                    case (pointer_code)
                        2'h0:    next_mix = colour0; // R13
                        2'h1:    next_mix = colour1;
                        2'h2:    next_mix = colour2;
                        default: next_mix = frame_pix;
                    endcase
                end
                FMT_FOUR_COLOUR: begin
                    case (pointer_code)
                        2'h0:    next_mix = colour0; // R14
                        2'h1:    next_mix = colour1;
                        2'h2:    next_mix = colour2;
                        default: next_mix = colour3;
                    endcase
                end
                FMT_ARGB: begin
                    next_mix = blend_pix; // R15
                end
                FMT_MASKED_ARGB: begin
                    if (argb_alpha == 8'h00) begin
                        next_mix = cursor_view; // R16
                    end else if (argb_alpha == 8'hff) begin
                        next_mix = cursor_view ^ frame_pix;
                    end else begin
                        next_mix = frame_pix;
                    end
                end
                default: begin
                    next_mix = frame_pix; // R22
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mix_valid <= 1'b0;
        end else begin
            mix_valid <= pix_valid; // R19
        end
    end

    // The merged pixel leaves before colour lookup and gamma, so cursor
    // colours are corrected together with the frame.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mix_pix <= 24'h0;
        end else begin
            mix_pix <= next_mix & width_mask; // R19
        end
    end

endmodule // hco_overlay

`default_nettype wire

// file: verif/hco_overlay_sva.sv
/* Concurrent checks on the ports of hco_overlay, bound to every instance.
   Assumes the bench keeps pix_valid and both strobes low until reset is released. */
`timescale 1ns/1ps
`include "hco_defines.svh"
`default_nettype none
module hco_overlay_sva
    import hco_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [31:0] fetch_base,
    input wire logic        fetch_enable,
    input wire logic [31:0] fetch_addr,
    input wire logic [6:0]  pointer_side_px,
    input wire logic        pix_valid,
    input wire logic        pointer_hit,
    input wire hco_bpp_t    display_bpp,
    input wire logic [23:0] frame_pix,
    input wire logic        mix_valid,
    input wire logic [23:0] mix_pix
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside its answer cycle");
    a_ctrl_reserved_zero: assert property ($past(reg_rd && reg_addr == `HCO_OFF_CONTROL) |-> reg_rdata[31:7] == 25'h0)
        else $error("control read shows reserved bits");
    a_state_reserved_zero: assert property ($past(reg_rd && reg_addr == `HCO_OFF_STATE) |-> reg_rdata[30:7] == 24'h0)
        else $error("status read shows reserved bits");
    a_show_gates_fetch: assert property ($past(reg_rd && reg_addr == `HCO_OFF_STATE) && !reg_rdata[0] |-> !fetch_enable)
        else $error("fetch enabled while pointer shown as off");
    a_fetch_addr_aligned: assert property (fetch_enable |-> fetch_addr == ($past(fetch_base) & 32'hffff_ff80))
        else $error("fetch address not aligned base");
    a_side_px_legal: assert property (pointer_side_px inside {7'h20, 7'h30, 7'h40})
        else $error("pointer side not 32, 48 or 64");
    a_mix_valid_follow: assert property (mix_valid == $past(pix_valid))
        else $error("mix valid not one cycle after pixel valid");
    a_miss_frame_pass: assert property (pix_valid && !pointer_hit && display_bpp == BPP_32 |=> mix_pix == $past(frame_pix))
        else $error("frame pixel altered outside pointer");
    a_depth8_blue_only: assert property (pix_valid && display_bpp == BPP_8 |=> mix_pix[23:8] == 16'h0)
        else $error("8 bpp output uses more than one byte");

    c_state_read: cover property (reg_rd && reg_addr == `HCO_OFF_STATE);
    c_fetch_on: cover property ($rose(fetch_enable));
    c_hit_pixel: cover property (pix_valid && pointer_hit);
endmodule // hco_overlay_sva
bind hco_overlay hco_overlay_sva u_sva (.sys_clk, .resetn, .reg_addr, .reg_rd, .reg_rdata, .fetch_base,
    .fetch_enable, .fetch_addr, .pointer_side_px, .pix_valid, .pointer_hit, .display_bpp, .frame_pix,
    .mix_valid, .mix_pix);
`default_nettype wire

// file: verif/tb.sv
/* Self-checking bench for hco_overlay: register sequences and pixel merges.
   Assumes a 40 MHz clock and the register map of hco_defines.svh. */
`timescale 1ns/1ps
`include "hco_defines.svh"
`default_nettype none
module tb;
    import hco_pkg::*;
    logic sys_clk, resetn, reg_wr, reg_rd, stop, vblank_pulse, pix_valid, pointer_hit, fetch_enable, mix_valid;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, fetch_base, pointer_argb, fetch_addr;
    logic [23:0] frame_pix, mix_pix;
    logic [23:0] c [4];
    logic [1:0]  pointer_code;
    logic [6:0]  pointer_side_px;
    hco_bpp_t    display_bpp;
    int          bad_count, checked;

    hco_overlay dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .display_engine_stopped_flag(stop), .vblank_pulse, .display_bpp, .fetch_base, .fetch_enable,
        .fetch_addr, .pointer_side_px, .colour0(c[0]), .colour1(c[1]), .colour2(c[2]), .colour3(c[3]),
        .pix_valid, .frame_pix, .pointer_hit, .pointer_code, .pointer_argb, .mix_valid, .mix_pix);

    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge sys_clk) begin reg_addr <= a; reg_rd <= 1'b1; end
        @(posedge sys_clk) reg_rd <= 1'b0;
        @(negedge sys_clk) cmp("reg_rdata", e, reg_rdata);
    endtask
    task automatic vblank();
        @(posedge sys_clk) vblank_pulse <= 1'b1;
        @(posedge sys_clk) vblank_pulse <= 1'b0;
    endtask
    // Settings applied with the engine stopped land at once, which keeps mode sweeps short.
    task automatic live(logic [31:0] d);
        @(posedge sys_clk) stop <= 1'b1;
        wr(`HCO_OFF_CONTROL, d);
        @(posedge sys_clk) stop <= 1'b0;
    endtask
    task automatic px(logic h, logic [1:0] k, logic [31:0] a, logic [23:0] f, logic [23:0] e);
        @(posedge sys_clk) begin pix_valid <= 1'b1; pointer_hit <= h; pointer_code <= k; pointer_argb <= a; frame_pix <= f; end
        @(posedge sys_clk) pix_valid <= 1'b0;
        @(negedge sys_clk) cmp("mix_pix", {8'h0, e}, {8'h0, mix_pix});
        cmp("mix_valid", 32'h1, {31'h0, mix_valid});
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [23:0] pal(int f, int k, logic [23:0] fr);
        case (f)
            0: return k == 2 ? fr : k == 3 ? ~fr : c[k];
            1: return k == 3 ? fr : c[k];
            default: return c[k];
        endcase
    endfunction
    // The design divides by 256, so the bench does the same.
    function automatic logic [23:0] blend(logic [31:0] p, logic [23:0] f);
        logic [7:0]  a;
        logic [23:0] r;
        a = p[31:24];
        for (int i = 0; i < 24; i += 8) begin
            r[i+:8] = 8'((16'(a) * 16'(p[i+:8]) + 16'(8'hff - a) * 16'(f[i+:8])) >> 8);
        end
        return r;
    endfunction

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        {resetn, reg_wr, reg_rd, stop, vblank_pulse, pix_valid, pointer_hit} = 7'h0;
        {reg_addr, reg_wdata, pointer_argb, pointer_code, frame_pix} = 98'h0;
        display_bpp = BPP_32;
        fetch_base = 32'hcafe_f0ff;
        c = '{24'h0000aa, 24'h00bb00, 24'hcc0000, 24'hdddddd};
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cmp("pointer_side_px", 32'h20, {25'h0, pointer_side_px});
        rd(`HCO_OFF_CONTROL, 32'h0);
        rd(`HCO_OFF_STATE, 32'h0);
        wr(`HCO_OFF_CONTROL, 32'h23);
        rd(`HCO_OFF_CONTROL, 32'h23);
        vblank();
        rd(`HCO_OFF_STATE, 32'h0);
        wr(`HCO_OFF_POSITION, 32'h0);
        rd(`HCO_OFF_STATE, 32'h8000_0000);
        vblank();
        rd(`HCO_OFF_STATE, 32'h23);
        cmp("pointer_side_px", 32'h30, {25'h0, pointer_side_px});
        cmp("fetch_addr", 32'hcafe_f080, fetch_addr);
        wr(`HCO_OFF_CONTROL, 32'h34);
        wr(`HCO_OFF_POSITION, 32'h0);
        wr(`HCO_OFF_STATE, 32'h8000_0000);
        rd(`HCO_OFF_STATE, 32'h23);
        vblank();
        rd(`HCO_OFF_STATE, 32'h23);
        wr(`HCO_OFF_POSITION, 32'h0);
        fork
            wr(`HCO_OFF_STATE, 32'h8000_0000);
            vblank();
        join
        rd(`HCO_OFF_STATE, 32'h23);
        wr(`HCO_OFF_POSITION, 32'h0);
        cmp("fetch_enable", 32'h1, {31'h0, fetch_enable});
        vblank();
        rd(`HCO_OFF_STATE, 32'h34);
        cmp("fetch_enable", 32'h0, {31'h0, fetch_enable});
        cmp("pointer_side_px", 32'h40, {25'h0, pointer_side_px});
        wr(`HCO_OFF_POSITION, 32'h0);
        fork
            wr(`HCO_OFF_POSITION, 32'h0);
            vblank();
        join
        rd(`HCO_OFF_STATE, 32'h8000_0034);
        wr(`HCO_OFF_STATE, 32'h8000_0000);
        rd(`HCO_OFF_POSITION, 32'h0);
        wr(8'h88, 32'hffff_ffff);
        rd(8'h88, 32'h0);
        live(32'h45);
        rd(`HCO_OFF_STATE, 32'h45);
        for (int f = 0; f < 3; f++) begin
            live({25'h0, 3'(f), 4'h1});
            for (int k = 0; k < 4; k++) px(1'b1, 2'(k), 32'h0, 24'h123456, pal(f, k, 24'h123456));
        end
        px(1'b0, 2'h0, 32'h0, 24'h654321, 24'h654321);
        live(32'h31);
        px(1'b1, 2'h0, 32'h80ff0080, 24'h123456, blend(32'h80ff0080, 24'h123456));
        live(32'h41);
        px(1'b1, 2'h0, 32'h00ff0080, 24'h123456, 24'hff0080);
        px(1'b1, 2'h0, 32'h7fff0080, 24'h123456, 24'h123456);
        px(1'b1, 2'h0, 32'hffff0080, 24'h123456, 24'hed34d6);
        @(posedge sys_clk) display_bpp <= BPP_8;
        px(1'b1, 2'h0, 32'h00a1b2c3, 24'h000012, 24'h0000c3);
        @(posedge sys_clk) display_bpp <= BPP_16;
        px(1'b1, 2'h0, 32'h00a1b2c3, 24'h001234, 24'h000872);
        live(32'h31);
        px(1'b1, 2'h0, 32'h80a1b2c3, 24'h001234, 24'h000932);
        @(posedge sys_clk) display_bpp <= BPP_8;
        px(1'b1, 2'h0, 32'h80a1b2c3, 24'h000012, 24'h00006a);
        @(posedge sys_clk) display_bpp <= BPP_32;
        live(32'h40);
        px(1'b1, 2'h0, 32'h00ff0080, 24'h123456, 24'h123456);
        live(32'h51);
        px(1'b1, 2'h0, 32'h00ff0080, 24'h123456, 24'h123456);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
